// [verilog/pioc_regs.svh]
`ifndef PIOC_REGS_SVH
`define PIOC_REGS_SVH

// ---------------------------------------------------------------
// Port numbering and address layout
// ---------------------------------------------------------------
`define PIOC_NPORT        7
`define PIOC_NPHY         5
`define PIOC_PORT_W       3
`define PIOC_FIRST_PORT   3'h1
`define PIOC_OFF_W        8
`define PIOC_OFF_STATUS   8'h1B
`define PIOC_OFF_MASK     8'h1F
`define PIOC_OFF_OPCTL    8'h20

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PIOC_BIT_ACL      0
`define PIOC_BIT_PHY      1
`define PIOC_BIT_TTAG     2
`define PIOC_BIT_RLOOP    6
`define PIOC_BIT_LLOOP    7
`define PIOC_QS_MSB       1
`define PIOC_QS_LSB       0

// ---------------------------------------------------------------
// Reset values and write masks
// ---------------------------------------------------------------
`define PIOC_RST_STATUS   8'h00
`define PIOC_RST_MASK     8'h00
`define PIOC_RST_OPCTL    8'h00
`define PIOC_WMASK_MASK   8'h03
`define PIOC_WMASK_OPCTL  8'hC7
`define PIOC_ZERO8        8'h00

// ---------------------------------------------------------------
// Egress queue split encodings
// ---------------------------------------------------------------
`define PIOC_QS_ONE       2'h0
`define PIOC_QS_TWO       2'h1
`define PIOC_QS_FOUR      2'h2
`define PIOC_QS_RSVD      2'h3

`endif

// [verilog/pioc_pkg.sv]
package pioc_pkg;
  typedef logic [7:0] pioc_byte_t;
  typedef logic [1:0] pioc_qsplit_t;
  typedef enum logic [2:0] {
    PIOC_Q1 = 3'h1,
    PIOC_Q2 = 3'h2,
    PIOC_Q4 = 3'h4
  } pioc_qmode_e;
endpackage

// [verilog/pioc_irq_port.sv]
`timescale 1ns/1ns
`include "pioc_regs.svh"

// Interrupt status and mask of one port
module pioc_irq_port
  import pioc_pkg::*;
#(
  parameter bit HAS_PHY = 1'b1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Register writes
  input  wire logic mask_we,
  input  wire logic [7:0] wdata,
  // Event sources
  input  wire logic acl_evt,
  input  wire logic phy_irq_lvl,
  // Register contents
  output logic [7:0] status_q,
  output logic [7:0] mask_q,
  output logic       irq_d
);

  logic acl_clr;
  logic phy_stat;

  // ---------------------------------------------------------------
  // Mask register
  // ---------------------------------------------------------------
  // Reserved bits never stored, so they read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_q <= `PIOC_RST_MASK;
    end else if (mask_we) begin
      mask_q <= wdata & `PIOC_WMASK_MASK;
    end
  end

  // Any change of the ACL mask bit clears the ACL status
  assign acl_clr = mask_we &&
    (wdata[`PIOC_BIT_ACL] != mask_q[`PIOC_BIT_ACL]);

  // MAC-only ports have no PHY source at all
  assign phy_stat = HAS_PHY ? phy_irq_lvl : 1'b0;

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  // New ACL event wins over a same-cycle toggle clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= `PIOC_RST_STATUS;
    end else begin
      status_q[7:2] <= 6'h00;
      status_q[`PIOC_BIT_PHY] <= phy_stat;
      if (acl_evt) begin
        status_q[`PIOC_BIT_ACL] <= 1'b1;
      end else if (acl_clr) begin
        status_q[`PIOC_BIT_ACL] <= 1'b0;
      end
    end
  end

  // Active-low enables; PHY enable only counts on PHY ports
  assign irq_d =
    (status_q[`PIOC_BIT_ACL] & ~mask_q[`PIOC_BIT_ACL]) |
    (HAS_PHY & status_q[`PIOC_BIT_PHY] &
     ~mask_q[`PIOC_BIT_PHY]);

endmodule

// [verilog/pioc_opctl_port.sv]
`timescale 1ns/1ns
`include "pioc_regs.svh"

// Operation control register of one port
module pioc_opctl_port
  import pioc_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Register write
  input  wire logic we,
  input  wire logic [7:0] wdata,
  // Register contents
  output logic [7:0] opctl_q
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Bits 5:3 reserved, dropped on write
  always_ff @(posedge mclk) begin
    if (srst) begin
      opctl_q <= `PIOC_RST_OPCTL;
    end else if (we) begin
      opctl_q <= wdata & `PIOC_WMASK_OPCTL;
    end
  end

endmodule

// [verilog/pioc_port_regs.sv]
`timescale 1ns/1ns
`include "pioc_regs.svh"

module pioc_port_regs
  import pioc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Register access from management interface
  input  wire logic [2:0]  reg_port,
  input  wire logic [7:0]  reg_off,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Interrupt sources, one bit per port (bit 0 = port 1)
  input  wire logic [6:0]  acl_evt,
  input  wire logic [6:0]  phy_irq,
  // Interrupt requests toward global interrupt logic
  output logic      [6:0]  port_irq,
  // Per-port control toward MAC and queue manager
  output logic      [6:0]  lloop_en,
  output logic      [6:0]  rloop_en,
  output logic      [6:0]  ttag_en,
  output logic      [13:0] qsplit,
  output logic      [20:0] qmode,
  // xMII remote loopback data path (ports 6 and 7)
  input  wire logic [7:0]  mii_txd_6,
  input  wire logic [7:0]  mii_txd_7,
  input  wire logic [7:0]  mii_rxd_core_6,
  input  wire logic [7:0]  mii_rxd_core_7,
  output logic      [7:0]  mii_rxd_6,
  output logic      [7:0]  mii_rxd_7
);

  // Storage arrays, one entry per port
  pioc_byte_t status_a [`PIOC_NPORT];
  pioc_byte_t mask_a   [`PIOC_NPORT];
  pioc_byte_t opctl_a  [`PIOC_NPORT];
  logic [6:0] irq_d;
  logic [6:0] acl_s1;
  logic [6:0] acl_s2;
  logic [6:0] acl_s3;
  logic [6:0] phy_s1;
  logic [6:0] phy_s2;
  logic [6:0] sel;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Port number to one-hot copy select; 0 selects nothing
  function automatic logic [6:0] port_sel(input logic [2:0] p);
    logic [6:0] s;
    s = 7'h00;
    if (p >= `PIOC_FIRST_PORT) begin
      s[p - `PIOC_FIRST_PORT] = 1'b1;
    end
    return s;
  endfunction

  // Queue split field to queue-count one-hot; reserved maps to one
  function automatic pioc_qmode_e qs_decode(input pioc_qsplit_t q);
    pioc_qmode_e m;
    m = PIOC_Q1;
    if (q == `PIOC_QS_TWO) begin
      m = PIOC_Q2;
    end else if (q == `PIOC_QS_FOUR) begin
      m = PIOC_Q4;
    end
    return m;
  endfunction

  assign sel = port_sel(reg_port);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Sources come from other logic; third stage finds ACL edges only
  always_ff @(posedge mclk) begin
    if (srst) begin
      acl_s1 <= 7'h00;
      acl_s2 <= 7'h00;
      acl_s3 <= 7'h00;
      phy_s1 <= 7'h00;
      phy_s2 <= 7'h00;
    end else begin
      acl_s1 <= acl_evt;
      acl_s2 <= acl_s1;
      acl_s3 <= acl_s2;
      phy_s1 <= phy_irq;
      phy_s2 <= phy_s1;
    end
  end

  // ---------------------------------------------------------------
  // Per-port register copies
  // ---------------------------------------------------------------
  // Ports 1-5 have a PHY, 6-7 are MAC only; all have ACL
  for (genvar i = 0; i < `PIOC_NPORT; i++) begin : g_port
    pioc_irq_port #(
      .HAS_PHY (i < `PIOC_NPHY)
    ) u_irq (
      .mclk        (mclk),
      .srst        (srst),
      .mask_we     (reg_wr && sel[i] &&
                    reg_off == `PIOC_OFF_MASK),
      .wdata       (reg_wdata),
      .acl_evt     (acl_s2[i] & ~acl_s3[i]),
      .phy_irq_lvl (phy_s2[i]),
      .status_q    (status_a[i]),
      .mask_q      (mask_a[i]),
      .irq_d       (irq_d[i])
    );

    pioc_opctl_port u_opctl (
      .mclk    (mclk),
      .srst    (srst),
      .we      (reg_wr && sel[i] &&
                reg_off == `PIOC_OFF_OPCTL),
      .wdata   (reg_wdata),
      .opctl_q (opctl_a[i])
    );

    // Control outputs registered once more so they leave from flops
    always_ff @(posedge mclk) begin
      if (srst) begin
        port_irq[i]      <= 1'b0;
        lloop_en[i]      <= 1'b0;
        rloop_en[i]      <= 1'b0;
        ttag_en[i]       <= 1'b0;
        qsplit[2*i+:2]   <= `PIOC_QS_ONE;
        qmode[3*i+:3]    <= PIOC_Q1;
      end else begin
        port_irq[i]    <= irq_d[i];
        lloop_en[i]    <= opctl_a[i][`PIOC_BIT_LLOOP];
        rloop_en[i]    <= opctl_a[i][`PIOC_BIT_RLOOP];
        ttag_en[i]     <= opctl_a[i][`PIOC_BIT_TTAG];
        qsplit[2*i+:2] <=
          opctl_a[i][`PIOC_QS_MSB:`PIOC_QS_LSB];
        qmode[3*i+:3]  <=
          qs_decode(opctl_a[i][`PIOC_QS_MSB:`PIOC_QS_LSB]);
      end
    end
  end

  // ---------------------------------------------------------------
  // xMII remote loopback echo
  // ---------------------------------------------------------------
  // No elastic buffer: one flop of delay, so long bursts may slip
  always_ff @(posedge mclk) begin
    if (srst) begin
      mii_rxd_6 <= `PIOC_ZERO8;
      mii_rxd_7 <= `PIOC_ZERO8;
    end else begin
      mii_rxd_6 <= opctl_a[5][`PIOC_BIT_RLOOP] ?
                   mii_txd_6 : mii_rxd_core_6;
      mii_rxd_7 <= opctl_a[6][`PIOC_BIT_RLOOP] ?
                   mii_txd_7 : mii_rxd_core_7;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // One cycle after reg_rd; unmapped offset or port reads zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata  <= `PIOC_ZERO8;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= `PIOC_ZERO8;
      if (reg_rd && reg_port >= `PIOC_FIRST_PORT) begin
        if (reg_off == `PIOC_OFF_STATUS) begin
          reg_rdata <= status_a[reg_port - `PIOC_FIRST_PORT];
        end else if (reg_off == `PIOC_OFF_MASK) begin
          reg_rdata <= mask_a[reg_port - `PIOC_FIRST_PORT];
        end else if (reg_off == `PIOC_OFF_OPCTL) begin
          reg_rdata <= opctl_a[reg_port - `PIOC_FIRST_PORT];
        end
      end
    end
  end

endmodule

// [bench/pioc_port_regs_assertions.sv]
`timescale 1ns/1ns
// Pin-level checks on the port register group
module pioc_port_regs_assertions
  import pioc_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Register access
  input wire logic [2:0]  reg_port,
  input wire logic [7:0]  reg_off,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // Interrupts and controls
  input wire logic [6:0]  acl_evt,
  input wire logic [6:0]  port_irq,
  input wire logic [6:0]  lloop_en,
  input wire logic [6:0]  rloop_en,
  input wire logic [13:0] qsplit,
  input wire logic [20:0] qmode,
  // Port 6 loop data
  input wire logic [7:0]  mii_txd_6,
  input wire logic [7:0]  mii_rxd_6
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic op1_wr;
  logic mask1_q;
  // -----------------------------------------------------------
  // Port 1 shadow: irq timing only holds while unmasked
  // -----------------------------------------------------------
  assign op1_wr = reg_wr && reg_port == 3'h1 && reg_off == 8'h20;
  always_ff @(posedge mclk) begin
    if (srst) begin
      mask1_q <= 1'b0;
    end else if (reg_wr && reg_port == 3'h1 && reg_off == 8'h1F) begin
      mask1_q <= reg_wdata[0];
    end
  end
  property p_answer; reg_rd |=> reg_rvalid; endproperty
  a_answer: assert property (p_answer)
    else $error("read not answered next cycle");
  property p_cause; reg_rvalid |-> $past(reg_rd); endproperty
  a_cause: assert property (p_cause)
    else $error("answer without read");
  property p_rsvd; reg_rvalid |-> reg_rdata[5:3] == 3'h0 &&
    ($past(reg_off) == 8'h20 || reg_rdata[7:2] == 6'h00); endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");
  property p_rst; $past(srst) |-> port_irq == 7'h00 &&
    lloop_en == 7'h00 && rloop_en == 7'h00; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not clear after reset");
  property p_ctl; logic [7:0] d; (op1_wr, d = reg_wdata) |-> ##2
    lloop_en[0] == d[7] && rloop_en[0] == d[6]; endproperty
  a_ctl: assert property (p_ctl)
    else $error("loop controls do not follow write");
  property p_qm; logic [7:0] d; (op1_wr, d = reg_wdata) |-> ##2
    qsplit[1:0] == d[1:0] && qmode[2:0] == (d[1:0] == 2'h1 ? 3'h2 :
    d[1:0] == 2'h2 ? 3'h4 : 3'h1); endproperty
  a_qm: assert property (p_qm)
    else $error("queue mode mismatch");
  property p_acl; $rose(acl_evt[0]) && !mask1_q |-> ##[3:5] port_irq[0];
  endproperty
  a_acl: assert property (p_acl)
    else $error("acl event raised no irq");
  property p_loop; rloop_en[5] && $past(rloop_en[5]) |->
    mii_rxd_6 == $past(mii_txd_6); endproperty
  a_loop: assert property (p_loop)
    else $error("loop data not echoed");
  // Main scenarios reached
  c_wr: cover property (op1_wr);
  c_acl: cover property ($rose(acl_evt[0]) ##[3:5] port_irq[0]);
  c_loop: cover property (rloop_en[5] && mii_rxd_6 != 8'h00);
endmodule

bind pioc_port_regs pioc_port_regs_assertions u_chk (
  .mclk       (mclk),
  .srst       (srst),
  .reg_port   (reg_port),
  .reg_off    (reg_off),
  .reg_wr     (reg_wr),
  .reg_rd     (reg_rd),
  .reg_wdata  (reg_wdata),
  .reg_rdata  (reg_rdata),
  .reg_rvalid (reg_rvalid),
  .acl_evt    (acl_evt),
  .port_irq   (port_irq),
  .lloop_en   (lloop_en),
  .rloop_en   (rloop_en),
  .qsplit     (qsplit),
  .qmode      (qmode),
  .mii_txd_6  (mii_txd_6),
  .mii_rxd_6  (mii_rxd_6)
);

// [bench/pioc_host_model.sv]
`timescale 1ns/1ns
// Management host: one strobe per access, port 0 when idle
module pioc_host_model (
  // Clock
  input wire logic       mclk,
  // Register access
  output logic     [2:0] reg_port,
  output logic     [7:0] reg_off,
  output logic           reg_wr,
  output logic           reg_rd,
  output logic     [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid
);
  // Idle bus selects no port
  initial begin
    reg_port = 3'h0;
    reg_off = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Software keeps tail tag on one port, loop traffic short
  task automatic wr(input logic [2:0] p, input logic [7:0] o, d);
    @(posedge mclk);
    #1;
    {reg_port, reg_off, reg_wdata, reg_wr} = {p, o, d, 1'b1};
    @(posedge mclk);
    #1;
    {reg_port, reg_wdata, reg_wr} = {3'h0, ~d, 1'b0};
  endtask
  // Answer is taken right after the edge that follows its launch
  task automatic rd(input logic [2:0] p, input logic [7:0] o,
                    output logic [8:0] r);
    @(posedge mclk);
    #1;
    {reg_port, reg_off, reg_rd} = {p, o, 1'b1};
    @(posedge mclk);
    #1;
    {reg_port, reg_rd} = {3'h0, 1'b0};
    r = {reg_rvalid, reg_rdata};
  endtask
endmodule

// [bench/pioc_port_regs_bench.sv]
`timescale 1ns/1ns
// Self-checking bench for the port register group
module pioc_port_regs_bench;
  logic mclk, srst, reg_wr, reg_rd, reg_rvalid;
  logic [2:0] reg_port;
  logic [7:0] reg_off, reg_wdata, reg_rdata;
  logic [6:0] acl_evt, phy_irq, port_irq, lloop_en, rloop_en, ttag_en;
  logic [13:0] qsplit;
  logic [20:0] qmode;
  logic [7:0] mii_txd_6, mii_txd_7, mii_rxd_core_6, mii_rxd_core_7;
  logic [7:0] mii_rxd_6, mii_rxd_7;
  int num_errors = 0;
  int comparisons = 0;
  pioc_port_regs dut (.*);
  pioc_host_model host (.*);
  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [8:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] p, input logic [7:0] o, e);
    logic [8:0] r;
    host.rd(p, o, r);
    chk(r, {1'b1, e});
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Every copy starts at zero, port 0 reads zero
  task automatic t_reset();
    for (int p = 0; p < 8; p++) begin
      rchk(p[2:0], 8'h1B, 8'h00);
      rchk(p[2:0], 8'h1F, 8'h00);
      rchk(p[2:0], 8'h20, 8'h00);
    end
  endtask
  // Reserved bits dropped, one copy touched, all queue codes
  task automatic t_opctl();
    logic [2:0] qm [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
    host.wr(3'h3, 8'h20, 8'hFF);
    rchk(3'h3, 8'h20, 8'hC7);
    chk({2'h0, lloop_en}, 9'h004);
    chk({2'h0, rloop_en}, 9'h004);
    chk({2'h0, ttag_en}, 9'h004);
    chk({3'h0, qsplit[5:0]}, 9'h030);
    chk(qmode[8:0], 9'h049);
    host.wr(3'h3, 8'h1F, 8'hFF);
    rchk(3'h3, 8'h1F, 8'h03);
    host.wr(3'h3, 8'h1B, 8'hFF);
    rchk(3'h3, 8'h1B, 8'h00);
    host.wr(3'h3, 8'h20, 8'h00);
    for (int q = 0; q < 4; q++) begin
      host.wr(3'h1, 8'h20, q[7:0]);
      tick(1);
      chk({7'h0, qsplit[1:0]}, q[8:0]);
      chk({6'h0, qmode[2:0]}, {6'h0, qm[q]});
    end
  endtask
  // Sticky ACL status cleared only by mask toggle
  task automatic t_acl();
    acl_evt = 7'h41;
    tick(1);
    acl_evt = 7'h00;
    tick(6);
    rchk(3'h1, 8'h1B, 8'h01);
    chk({2'h0, port_irq}, 9'h041);
    host.wr(3'h1, 8'h1B, 8'h00);
    rchk(3'h1, 8'h1B, 8'h01);
    host.wr(3'h1, 8'h1F, 8'h01);
    rchk(3'h1, 8'h1B, 8'h00);
    acl_evt = 7'h01;
    tick(1);
    acl_evt = 7'h00;
    tick(6);
    chk({2'h0, port_irq}, 9'h040);
    host.wr(3'h1, 8'h1F, 8'h00);
    rchk(3'h1, 8'h1B, 8'h00);
    // Event and toggle land on one edge: the event must win
    acl_evt = 7'h02;
    tick(1);
    acl_evt = 7'h00;
    host.wr(3'h2, 8'h1F, 8'h01);
    rchk(3'h2, 8'h1B, 8'h01);
  endtask
  // PHY level follows, masked on port 1, absent on 6
  task automatic t_phy();
    phy_irq = 7'h21;
    tick(5);
    rchk(3'h1, 8'h1B, 8'h02);
    rchk(3'h6, 8'h1B, 8'h00);
    chk({2'h0, port_irq}, 9'h041);
    host.wr(3'h1, 8'h1F, 8'h02);
    tick(2);
    chk({2'h0, port_irq}, 9'h040);
    phy_irq = 7'h00;
    tick(5);
    rchk(3'h1, 8'h1B, 8'h00);
  endtask
  // Port 6 echoes transmit data, port 7 keeps core data
  task automatic t_loop();
    {mii_txd_6, mii_rxd_core_6, mii_rxd_core_7} = 24'hA53C96;
    host.wr(3'h6, 8'h20, 8'h40);
    tick(3);
    chk({1'b0, mii_rxd_6}, 9'h0A5);
    chk({1'b0, mii_rxd_7}, 9'h096);
    host.wr(3'h6, 8'h20, 8'h00);
    tick(3);
    chk({1'b0, mii_rxd_6}, 9'h03C);
    // Port 7 loops on its own, port 6 back to core data
    mii_txd_7 = 8'h5A;
    host.wr(3'h7, 8'h20, 8'h40);
    tick(3);
    chk({1'b0, mii_rxd_7}, 9'h05A);
    chk({2'h0, rloop_en}, 9'h040);
    chk({1'b0, mii_rxd_6}, 9'h03C);
  endtask
  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Watchdog, well past the expected run length
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    {srst, acl_evt, phy_irq} = {1'b1, 14'h0};
    {mii_txd_6, mii_txd_7, mii_rxd_core_6, mii_rxd_core_7} = 32'h0;
    tick(12);
    srst = 1'b0;
    t_reset();
    t_opctl();
    t_acl();
    t_phy();
    t_loop();
    finish_test();
  end
endmodule
